//--- src/uart_ctrl2_pkg.sv
`default_nettype none
package uart_ctrl2_pkg;

   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_CFG = 8'h04;
   localparam logic [7:0] OFS_EVT = 8'h08;
   localparam logic [7:0] OFS_MASK = 8'h0c;
   localparam logic [7:0] OFS_STAT = 8'h10;

   // Reset values
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [5:0] CFG_RESET = 6'h00;
   localparam logic [2:0] EVT_RESET = 3'h0;
   localparam logic [2:0] MASK_RESET = 3'h0;

   // Event bit positions
   localparam int EVT_WAKE = 0;
   localparam int EVT_BREAK = 1;
   localparam int EVT_IDLE = 2;
   localparam int EVT_W = 3;

   // Status word field positions
   localparam int STAT_ACTIVE = 0;
   localparam int STAT_TX_OWN = 1;
   localparam int STAT_RX_OWN = 2;
   localparam int STAT_STANDBY = 3;
   localparam int STAT_FLAGS = 4;

   // Frame lengths in bit times
   localparam logic [3:0] LEN_CHAR8 = 4'ha;
   localparam logic [3:0] LEN_CHAR9 = 4'hb;
   localparam logic [3:0] LEN_BRK_LONG8 = 4'hd;
   localparam logic [3:0] LEN_BRK_LONG9 = 4'he;

   // Clock cycles per bit time
   localparam logic [15:0] BAUD_DIV_DEFAULT = 16'h0010;

   typedef struct packed {
      logic xmit_empty_irq_en;
      logic xmit_done_irq_en;
      logic rx_full_irq_en;
      logic line_quiet_irq_en;
      logic xmit_on;
      logic rcv_on;
      logic rx_standby;
      logic queue_break;
   } ctrl_type;

   typedef struct packed {
      logic long_break;
      logic nine_bit;
      logic wake_method;
      logic single_wire_dir;
      logic rx_source_sel;
      logic loop_mode;
   } cfg_type;

   typedef struct packed {
      logic tx_buffer_empty;
      logic xmit_done;
      logic rx_buffer_full;
      logic line_quiet;
   } flags_type;

   typedef struct packed {
      logic char_done;
      logic msb;
      logic line_idle;
   } rx_evt_type;

   typedef struct packed {
      logic hsel;
      logic [31:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
      logic hready;
      logic [31:0] hwdata;
   } ahb_req_type;

   typedef struct packed {
      logic hreadyout;
      logic hresp;
      logic [31:0] hrdata;
   } ahb_rsp_type;

   typedef enum logic [1:0] {
      K_NONE = 2'b00,
      K_DATA = 2'b01,
      K_IDLE = 2'b10,
      K_BREAK = 2'b11
   } tx_kind_type;

   typedef struct packed {
      logic [14:0] shift;
      logic [3:0] cnt;
      logic line;
      logic busy;
      logic done;
   } shift_state_type;

   localparam shift_state_type SHIFT_RESET = '{shift: 15'h7fff, cnt: 4'h0,
      line: 1'b1, busy: 1'b0, done: 1'b0};

endpackage
`default_nettype wire

//--- src/frame_shifter.sv
`default_nettype none
module frame_shifter
   import uart_ctrl2_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // Control
   input wire logic tick_i,
   input wire logic load_i,
   input wire logic [14:0] pattern_i,
   input wire logic [3:0] length_i,
   // Line
   output logic line_o,
   output logic busy_o,
   output logic done_o
);

   shift_state_type s_q, s_d;

   // First bit may be short: it ends at the next tick
   always_comb begin
      s_d = s_q;
      s_d.done = 1'b0;
      if (load_i) begin
         s_d.shift = pattern_i;
         s_d.cnt = length_i;
         s_d.line = pattern_i[0];
         s_d.busy = 1'b1;
      end else if (s_q.busy && tick_i) begin
         if (s_q.cnt == 4'h1) begin
            s_d.busy = 1'b0;
            s_d.line = 1'b1;
            s_d.done = 1'b1;
         end else begin
            s_d.shift = {1'b1, s_q.shift[14:1]};
            s_d.line = s_q.shift[1];
            s_d.cnt = s_q.cnt - 4'h1;
         end
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s_q <= SHIFT_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   assign line_o = s_q.line;
   assign busy_o = s_q.busy;
   assign done_o = s_q.done;

   a_idle_high: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      !s_q.busy |-> s_q.line) else $error("line not high between frames");

endmodule
`default_nettype wire

//--- src/uart_control_two.sv
// Behaviour
// - Empty-buffer flag interrupts when its enable set
// - Transmit-done flag interrupts when its enable set
// - Receive-full flag interrupts when its enable set
// - Idle-line flag interrupts when its enable set
// - Transmitter runs and drives pin only when on
// - Single-wire direction bit sets pin direction
// - Re-enabling transmitter mid-frame queues idle character
// - Pin stays driven until pending frames finish
// - Receiver off releases receive pin
// - Loop mode releases receive pin always
// - Standby bit waits for selected wakeup condition
// - Hardware clears standby bit on wakeup
// - Writing break bit one then zero queues break
// - Break bit held keeps queuing break characters
// - A second break may slip in before clear
// - Frame is start, eight or nine bits, stop
// - Loop mode feeds receiver from transmit node
//
// Chosen here: the address map and the AHB-Lite register port.
`default_nettype none
module uart_control_two
   import uart_ctrl2_pkg::*;
#(
   parameter logic [15:0] BAUD_DIV = BAUD_DIV_DEFAULT
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // Register bus
   input wire ahb_req_type ahb_i,
   output ahb_rsp_type ahb_o,
   // Flags and receiver events
   input wire flags_type flags_i,
   input wire rx_evt_type rx_evt_i,
   // Transmit data
   input wire logic tx_valid_i,
   input wire logic [8:0] tx_data_i,
   output logic tx_ready_o,
   // Pins
   output logic txd_o,
   output logic txd_oe_o,
   input wire logic txd_pin_i,
   input wire logic rxd_i,
   output logic rx_pin_own_o,
   // Receiver side
   output logic rx_line_o,
   output logic rcv_enable_o,
   output logic rx_standby_o,
   output logic nine_bit_o,
   output logic tx_active_o,
   // Interrupt
   output logic irq_o
);

   typedef struct packed {
      ctrl_type ctrl;
      cfg_type cfg;
      logic [EVT_W-1:0] evt;
      logic [EVT_W-1:0] mask;
      logic dp_read;
      logic dp_write;
      logic rd_done;
      logic [7:0] dp_addr;
      logic [31:0] rdata;
      logic [15:0] div_cnt;
      logic tick;
      logic brk_pend;
      logic idle_pend;
      tx_kind_type kind;
   } main_state_type;

   localparam main_state_type MAIN_RESET = '{ctrl: CTRL_RESET, cfg: CFG_RESET,
      evt: EVT_RESET, mask: MASK_RESET, dp_read: 1'b0, dp_write: 1'b0,
      rd_done: 1'b0, dp_addr: 8'h00, rdata: 32'h0000_0000,
      div_cnt: 16'h0000, tick: 1'b0, brk_pend: 1'b0, idle_pend: 1'b0,
      kind: K_NONE};

   main_state_type s_q, s_d;

   logic load;
   logic [14:0] pattern;
   logic [3:0] length;
   logic shift_line;
   logic shift_done;
   logic accept;
   logic sw_rx;
   logic tx_own;
   logic [EVT_W-1:0] evt_set;
   logic [EVT_W-1:0] evt_clr;
   ctrl_type ctrl_new;

   function automatic logic [14:0] frame_pattern(input tx_kind_type k,
         input logic [8:0] d, input logic nine);
      if (k == K_BREAK) begin
         return 15'h0000;
      end else if (k == K_IDLE) begin
         return 15'h7fff;
      end else if (nine) begin
         return {4'hf, 1'b1, d[8], d[7:0], 1'b0};
      end
      return {5'h1f, 1'b1, d[7:0], 1'b0};
   endfunction

   function automatic logic [3:0] frame_length(input tx_kind_type k,
         input cfg_type c);
      logic [3:0] base;
      base = c.nine_bit ? LEN_CHAR9 : LEN_CHAR8;
      if (k == K_BREAK && c.long_break) begin
         return c.nine_bit ? LEN_BRK_LONG9 : LEN_BRK_LONG8;
      end
      return base;
   endfunction

   function automatic logic [31:0] reg_read(input logic [7:0] a,
         input main_state_type s, input logic [7:0] st);
      if (a == OFS_CTRL) begin
         return {24'h000000, s.ctrl};
      end else if (a == OFS_CFG) begin
         return {26'h0000000, s.cfg};
      end else if (a == OFS_EVT) begin
         return {29'h00000000, s.evt};
      end else if (a == OFS_MASK) begin
         return {29'h00000000, s.mask};
      end else if (a == OFS_STAT) begin
         return {24'h000000, st};
      end
      return 32'h0000_0000;
   endfunction

   // Single-wire mode with the line turned inward
   assign sw_rx = s_q.cfg.loop_mode && s_q.cfg.rx_source_sel
      && !s_q.cfg.single_wire_dir;

   assign tx_active_o = (s_q.kind != K_NONE) || s_q.brk_pend || s_q.idle_pend;
   assign tx_own = s_q.ctrl.xmit_on || tx_active_o;
   assign accept = ahb_i.hsel && ahb_i.htrans[1] && ahb_i.hready;

   always_comb begin
      s_d = s_q;
      load = 1'b0;
      pattern = 15'h7fff;
      length = LEN_CHAR8;
      evt_set = '0;
      evt_clr = '0;
      ctrl_new = s_q.ctrl;
      s_d.tick = 1'b0;

      if (s_q.div_cnt == BAUD_DIV - 16'h0001) begin
         s_d.div_cnt = 16'h0000;
         s_d.tick = 1'b1;
      end else begin
         s_d.div_cnt = s_q.div_cnt + 16'h0001;
      end

      // Frame end
      if (shift_done) begin
         if (s_q.kind == K_BREAK) begin
            evt_set[EVT_BREAK] = 1'b1;
         end
         if (s_q.kind == K_IDLE) begin
            evt_set[EVT_IDLE] = 1'b1;
         end
         s_d.kind = K_NONE;
      end

      // Start next frame; break before idle before data
      if (s_q.kind == K_NONE) begin
         if (s_q.brk_pend || (s_q.ctrl.queue_break && s_q.ctrl.xmit_on)) begin
            s_d.kind = K_BREAK;
            s_d.brk_pend = 1'b0;
         end else if (s_q.idle_pend) begin
            s_d.kind = K_IDLE;
            s_d.idle_pend = 1'b0;
         end else if (tx_valid_i && tx_ready_o) begin
            s_d.kind = K_DATA;
         end
         load = s_d.kind != K_NONE;
         pattern = frame_pattern(s_d.kind, tx_data_i, s_q.cfg.nine_bit);
         length = frame_length(s_d.kind, s_q.cfg);
      end

      // Hardware wakeup; a same-cycle software write still wins
      if (s_q.ctrl.rx_standby) begin
         if ((!s_q.cfg.wake_method && rx_evt_i.line_idle)
               || (s_q.cfg.wake_method && rx_evt_i.char_done && rx_evt_i.msb)) begin
            s_d.ctrl.rx_standby = 1'b0;
            evt_set[EVT_WAKE] = 1'b1;
         end
      end

      // Write data phase
      if (s_q.dp_write) begin
         if (s_q.dp_addr == OFS_CTRL) begin
            ctrl_new = ctrl_type'(ahb_i.hwdata[7:0]);
            if (ctrl_new.xmit_on && !s_q.ctrl.xmit_on && tx_active_o) begin
               s_d.idle_pend = 1'b1;
            end
            if (ctrl_new.queue_break && ctrl_new.xmit_on) begin
               s_d.brk_pend = 1'b1;
            end
            s_d.ctrl = ctrl_new;
         end else if (s_q.dp_addr == OFS_CFG) begin
            s_d.cfg = cfg_type'(ahb_i.hwdata[5:0]);
         end else if (s_q.dp_addr == OFS_EVT) begin
            evt_clr = ahb_i.hwdata[EVT_W-1:0];
         end else if (s_q.dp_addr == OFS_MASK) begin
            s_d.mask = ahb_i.hwdata[EVT_W-1:0];
         end
      end

      // Set beats clear
      s_d.evt = (s_q.evt & ~evt_clr) | evt_set;

      // Reads take one wait state so the data come from a flop
      if (s_q.dp_read && !s_q.rd_done) begin
         s_d.rdata = reg_read(s_q.dp_addr, s_q,
            {flags_i, s_q.ctrl.rx_standby, rx_pin_own_o, tx_own, tx_active_o});
         s_d.rd_done = 1'b1;
      end

      if (ahb_i.hready) begin
         s_d.dp_read = accept && !ahb_i.hwrite;
         s_d.dp_write = accept && ahb_i.hwrite;
         s_d.dp_addr = ahb_i.haddr[7:0];
         s_d.rd_done = 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s_q <= MAIN_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   frame_shifter u_shifter (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .tick_i(s_q.tick),
      .load_i(load),
      .pattern_i(pattern),
      .length_i(length),
      .line_o(shift_line),
      .busy_o(),
      .done_o(shift_done)
   );

   assign ahb_o.hreadyout = !(s_q.dp_read && !s_q.rd_done);
   assign ahb_o.hresp = 1'b0;
   assign ahb_o.hrdata = s_q.rdata;

   // Data only once queued break and idle have gone out
   assign tx_ready_o = (s_q.kind == K_NONE) && s_q.ctrl.xmit_on
      && !s_q.brk_pend && !s_q.idle_pend && !s_q.ctrl.queue_break;

   assign txd_o = shift_line;
   assign txd_oe_o = tx_own && !sw_rx;
   assign rx_pin_own_o = s_q.ctrl.rcv_on && !s_q.cfg.loop_mode;
   // Internal loopback uses the shifter, single-wire uses the pin
   assign rx_line_o = !s_q.cfg.loop_mode ? rxd_i
      : (s_q.cfg.rx_source_sel ? txd_pin_i : shift_line);
   assign rcv_enable_o = s_q.ctrl.rcv_on;
   assign rx_standby_o = s_q.ctrl.rx_standby;
   assign nine_bit_o = s_q.cfg.nine_bit;

   // Flag levels plus sticky events
   assign irq_o = |({flags_i} & s_q.ctrl[7:4]) || |(s_q.evt & s_q.mask);

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!reset_n_i);

   logic ctrl_wr;
   assign ctrl_wr = s_q.dp_write && (s_q.dp_addr == OFS_CTRL);

   a_empty_irq: assert property (
      (flags_i.tx_buffer_empty && s_q.ctrl.xmit_empty_irq_en) |-> irq_o)
      else $error("empty flag interrupt missing");
   a_done_irq: assert property (
      (flags_i.xmit_done && s_q.ctrl.xmit_done_irq_en) |-> irq_o)
      else $error("done flag interrupt missing");
   a_full_irq: assert property (
      (flags_i.rx_buffer_full && s_q.ctrl.rx_full_irq_en) |-> irq_o)
      else $error("full flag interrupt missing");
   a_quiet_irq: assert property (
      (flags_i.line_quiet && s_q.ctrl.line_quiet_irq_en) |-> irq_o)
      else $error("idle flag interrupt missing");
   a_irq_cause: assert property (
      irq_o |-> (|(flags_i & s_q.ctrl[7:4]) || |(s_q.evt & s_q.mask)))
      else $error("interrupt without cause");
   a_tx_pin_drive: assert property (
      (s_q.ctrl.xmit_on && !sw_rx) |-> txd_oe_o)
      else $error("transmit pin not driven");
   a_single_dir: assert property (
      (s_q.cfg.loop_mode && s_q.cfg.rx_source_sel && !s_q.cfg.single_wire_dir)
      |-> !txd_oe_o) else $error("single wire pin driven while inward");
   a_idle_queue: assert property (
      (ctrl_wr && ahb_i.hwdata[3] && !s_q.ctrl.xmit_on && s_q.kind == K_DATA)
      |=> (s_q.idle_pend || s_q.kind == K_IDLE)) else $error("idle not queued");
   a_tx_hold: assert property (
      ($fell(s_q.ctrl.xmit_on) && s_q.kind != K_NONE && !sw_rx) |-> txd_oe_o)
      else $error("pin released during frame");
   a_rx_release: assert property (
      (!s_q.ctrl.rcv_on || s_q.cfg.loop_mode) |-> !rx_pin_own_o)
      else $error("receive pin held");
   a_wake_idle: assert property (
      (s_q.ctrl.rx_standby && !s_q.cfg.wake_method && rx_evt_i.line_idle
      && !ctrl_wr) |=> (!s_q.ctrl.rx_standby && s_q.evt[EVT_WAKE]))
      else $error("standby not cleared");
   a_break_queue: assert property (
      (ctrl_wr && ahb_i.hwdata[0] && ahb_i.hwdata[3])
      |=> (s_q.brk_pend || s_q.kind == K_BREAK)) else $error("break not queued");
   // The stop edge rises one cycle before the kind returns to none
   a_break_low: assert property (
      (s_q.kind == K_BREAK && !shift_done) |-> !txd_o) else $error("break line high");
   a_read_wait: assert property (
      (accept && !ahb_i.hwrite) |=> !ahb_o.hreadyout ##1 ahb_o.hreadyout)
      else $error("read wait state wrong");
   a_ctrl_write: assert property (
      ctrl_wr |=> (s_q.ctrl == $past(ahb_i.hwdata[7:0])))
      else $error("control write not kept");
   a_loop_feed: assert property (
      (s_q.cfg.loop_mode && !s_q.cfg.rx_source_sel) |-> (rx_line_o == txd_o))
      else $error("loopback not fed from shifter");
   a_stby_hold: assert property (
      (s_q.ctrl.rx_standby && !ctrl_wr && !rx_evt_i.line_idle && !rx_evt_i.char_done)
      |=> s_q.ctrl.rx_standby)
      else $error("standby left without wakeup");
   a_break_evt: assert property (
      (shift_done && s_q.kind == K_BREAK) |=> s_q.evt[EVT_BREAK])
      else $error("break event not set");
   a_tx_release: assert property (
      (!s_q.ctrl.xmit_on && !tx_active_o) |-> !txd_oe_o) else $error("pin held when idle");
   a_no_data_off: assert property (
      !s_q.ctrl.xmit_on |-> !tx_ready_o) else $error("data taken while off");

   c_break_sent: cover property (shift_done && s_q.kind == K_BREAK);
   c_idle_sent: cover property (shift_done && s_q.kind == K_IDLE);
   c_wakeup: cover property ($fell(s_q.ctrl.rx_standby));
   c_char_sent: cover property (shift_done && s_q.kind == K_DATA);
   c_two_breaks: cover property (s_q.kind == K_BREAK ##1 s_q.kind == K_NONE
      ##1 s_q.kind == K_BREAK);

endmodule
`default_nettype wire

//--- test/remote_uart.sv
`default_nettype none
module remote_uart
   import uart_ctrl2_pkg::*;
#(
   parameter int DIV = 4
) (
   // Clock
   input wire logic clk_i,
   // Serial lines
   input wire logic line_i,
   input wire logic nine_i,
   input wire logic pull_low_i,
   output logic line_o,
   // Capture
   output logic [9:0] data_o,
   output int chars_o,
   output int breaks_o,
   output int low_len_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // Released line rests high, as with a pull-up
   assign line_o = !pull_low_i;

   initial begin
      int n;
      chars_o = 0;
      breaks_o = 0;
      low_len_o = 0;
      data_o = '0;
      forever begin
         @(posedge clk_i);
         // Own pull on the line is not traffic
         if (line_i === 1'b0 && !pull_low_i) begin
            n = 0;
            while (line_i === 1'b0) begin
               n++;
               @(posedge clk_i);
            end
            low_len_o = n;
            if (n > DIV) begin
               breaks_o++;
            end else begin
               // Short start bit: bits timed from its end, so d0 must be 1
               repeat (DIV / 2) @(posedge clk_i);
               for (int i = 0; i < (nine_i ? 10 : 9); i++) begin
                  data_o[i] = line_i;
                  repeat (DIV) @(posedge clk_i);
               end
               chars_o++;
            end
         end
      end
   end
endmodule
`default_nettype wire

//--- test/uart_control_two_tb.sv
`default_nettype none
module uart_control_two_tb
   import uart_ctrl2_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int DIV = 4;
   logic clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   ahb_req_type rq = '0;
   ahb_req_type rqw;
   ahb_rsp_type rsp;
   flags_type flags = '0;
   rx_evt_type evt = '0;
   logic tx_valid = 1'b0;
   logic [8:0] tx_data = '0;
   logic pull_low = 1'b0;
   logic tx_ready, txd, txd_oe, txd_pin, rem_line, rx_own, rx_line;
   logic rcv_en, standby, nine, tx_act, irq;
   logic [9:0] cap;
   logic [31:0] rd;
   int chars, breaks, low_len, b0;
   int errors = 0;
   int num_checks = 0;
   logic [20:0] rows [12] = '{
      {8'h00, 6'h00, 4'hf, 3'h0}, {8'h80, 6'h00, 4'h8, 3'h4},
      {8'h70, 6'h00, 4'h8, 3'h0}, {8'h40, 6'h00, 4'h4, 3'h4},
      {8'h20, 6'h00, 4'h2, 3'h4}, {8'h10, 6'h00, 4'h1, 3'h4},
      {8'he0, 6'h00, 4'h1, 3'h0}, {8'h04, 6'h00, 4'h0, 3'h2},
      {8'h04, 6'h01, 4'h0, 3'h0}, {8'h08, 6'h00, 4'h0, 3'h1},
      {8'h08, 6'h03, 4'h0, 3'h0}, {8'h08, 6'h07, 4'h0, 3'h1}};

   always #4 clk_i = ~clk_i;
   always_comb begin
      rqw = rq;
      rqw.hready = rsp.hreadyout;
   end
   assign txd_pin = txd_oe ? txd : rem_line;

   uart_control_two #(.BAUD_DIV(16'h0004)) uart_control_two_inst (
      .clk_i(clk_i), .reset_n_i(reset_n_i), .ahb_i(rqw), .ahb_o(rsp),
      .flags_i(flags), .rx_evt_i(evt), .tx_valid_i(tx_valid), .tx_data_i(tx_data),
      .tx_ready_o(tx_ready), .txd_o(txd), .txd_oe_o(txd_oe), .txd_pin_i(txd_pin),
      .rxd_i(rem_line), .rx_pin_own_o(rx_own), .rx_line_o(rx_line),
      .rcv_enable_o(rcv_en), .rx_standby_o(standby), .nine_bit_o(nine),
      .tx_active_o(tx_act), .irq_o(irq));

   remote_uart #(.DIV(DIV)) remote_uart_inst (
      .clk_i(clk_i), .line_i(txd_pin), .nine_i(nine), .pull_low_i(pull_low),
      .line_o(rem_line), .data_o(cap), .chars_o(chars), .breaks_o(breaks),
      .low_len_o(low_len));

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      rq.hsel <= 1'b1;
      rq.haddr <= {24'h000000, a};
      rq.htrans <= 2'b10;
      rq.hwrite <= wr;
      rq.hsize <= 3'b010;
      do @(posedge clk_i); while (rsp.hreadyout !== 1'b1);
      rq.htrans <= 2'b00;
      rq.hsel <= 1'b0;
      rq.hwdata <= d;
      do @(posedge clk_i); while (rsp.hreadyout !== 1'b1);
      rd = rsp.hrdata;
   endtask

   // One more edge so callers see the written value settled
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
      cyc(1);
   endtask

   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(nm, exp, rd);
   endtask

   task automatic send(input logic [8:0] d);
      tx_data <= d;
      tx_valid <= 1'b1;
      do @(posedge clk_i); while (tx_ready !== 1'b1);
      tx_valid <= 1'b0;
   endtask

   // Activity shows only after the load edge
   task automatic wait_tx;
      cyc(1);
      for (int i = 0; i < 600 && tx_act !== 1'b0; i++) @(posedge clk_i);
      cyc(3);
   endtask

   task automatic pulse(input rx_evt_type e);
      evt <= e;
      @(posedge clk_i);
      evt <= '0;
      cyc(2);
   endtask

   task automatic final_report;
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   initial begin
      cyc(20000);
      errors++;
      final_report();
   end

   initial begin
      cyc(4);
      reset_n_i <= 1'b1;
      @(posedge clk_i);
      rdc("ctrl", OFS_CTRL, 32'h0);
      rdc("unmapped", 8'h14, 32'h0);
      chk("hresp", 0, rsp.hresp);
      chk("txd", 1, txd);
      chk("txd_oe", 0, txd_oe);
      chk("irq", 0, irq);
      $display("test reset done");
      foreach (rows[i]) begin
         wr(OFS_CTRL, {24'h0, rows[i][20:13]});
         wr(OFS_CFG, {26'h0, rows[i][12:7]});
         flags <= rows[i][6:3];
         cyc(2);
         chk("irq", rows[i][2], irq);
         chk("rx_own", rows[i][1], rx_own);
         chk("rcv_en", rows[i][15], rcv_en);
         chk("txd_oe", rows[i][0], txd_oe);
         rdc("ctrl", OFS_CTRL, {24'h0, rows[i][20:13]});
      end
      flags <= '0;
      pull_low <= 1'b1;
      wr(OFS_CFG, 32'h1);
      chk("rx_line", 1, rx_line);
      wr(OFS_CFG, 32'h3);
      chk("rx_line", 0, rx_line);
      pull_low <= 1'b0;
      wr(OFS_CFG, 32'h0);
      $display("test table done");
      wr(OFS_CTRL, 32'h08);
      send(9'h0a5);
      wait_tx();
      chk("char8", 9'h1a5, cap[8:0]);
      wr(OFS_CFG, 32'h10);
      send(9'h1a5);
      wait_tx();
      chk("char9", 10'h3a5, cap);
      wr(OFS_CFG, 32'h0);
      send(9'h0a5);
      wr(OFS_CTRL, 32'h0);
      chk("oe_held", 1, txd_oe);
      wait_tx();
      chk("oe_free", 0, txd_oe);
      chk("chars", 3, chars);
      $display("test transmit done");
      wr(OFS_CTRL, 32'h08);
      send(9'h0a5);
      wr(OFS_CTRL, 32'h0);
      wr(OFS_CTRL, 32'h08);
      wait_tx();
      rdc("evt_idle", OFS_EVT, 32'h4);
      wr(OFS_EVT, 32'h7);
      wr(OFS_CTRL, 32'h09);
      wr(OFS_CTRL, 32'h08);
      wait_tx();
      chk("breaks", 1, breaks);
      chk("brk_len", 1, low_len >= 9 * DIV && low_len <= 10 * DIV + 1);
      rdc("evt_brk", OFS_EVT, 32'h2);
      wr(OFS_CFG, 32'h20);
      wr(OFS_CTRL, 32'h09);
      wr(OFS_CTRL, 32'h08);
      wait_tx();
      chk("long_len", 1, low_len >= 12 * DIV && low_len <= 13 * DIV + 1);
      b0 = breaks;
      wr(OFS_CTRL, 32'h09);
      cyc(100);
      wr(OFS_CTRL, 32'h08);
      wait_tx();
      chk("brk_held", 1, breaks - b0 >= 2 || low_len >= 24 * DIV);
      $display("test break done");
      wr(OFS_EVT, 32'h7);
      wr(OFS_CFG, 32'h0);
      wr(OFS_CTRL, 32'h06);
      chk("standby", 1, standby);
      rdc("stat", OFS_STAT, 32'h0c);
      pulse(3'b110);
      chk("standby", 1, standby);
      pulse(3'b001);
      chk("woken", 0, standby);
      rdc("ctrl", OFS_CTRL, 32'h04);
      chk("irq", 0, irq);
      wr(OFS_MASK, 32'h1);
      cyc(1);
      chk("irq_evt", 1, irq);
      wr(OFS_EVT, 32'h1);
      cyc(1);
      chk("irq_clr", 0, irq);
      wr(OFS_CFG, 32'h8);
      wr(OFS_CTRL, 32'h06);
      pulse(3'b001);
      pulse(3'b100);
      chk("standby", 1, standby);
      pulse(3'b110);
      chk("woken", 0, standby);
      $display("test standby done");
      final_report();
   end
endmodule
`default_nettype wire
